// ==== logic/udsr_top.sv ====
// Command/data port, frame number, identity and interrupt source readout
`timescale 1ns/1ns
`default_nettype none

module udsr_top #(
  parameter int PTICK_CYCLES = udsr_pkg::PTICK_CYCLES
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire udsr_pkg::udsr_hreq_type hreq,
  input  wire udsr_pkg::udsr_evt_type  evt,
  input  wire logic [31:0]            irq_enable_mask,
  input  wire logic [31:0]            irq_clear,
  output logic [15:0]                 bus_dout,
  output logic                        bus_doe,
  output logic                        irq_out,
  output logic                        suspend_out,
  output logic                        locked_out
);

  localparam int CW = $clog2(PTICK_CYCLES + 1);
  localparam logic [CW-1:0] TICK_LAST = CW'(PTICK_CYCLES - 1);
  localparam logic [CW-1:0] CNT_ZERO  = '0;

  // ----------------------------------------------------------------
  // Word selection
  // ----------------------------------------------------------------
  function automatic logic [15:0] frame_word(input logic [udsr_pkg::FRAME_W-1:0] f);
    frame_word = {5'h00, f};
  endfunction : frame_word

  // ----------------------------------------------------------------
  // Bus state and pseudo frame tick
  // ----------------------------------------------------------------
  logic [CW-1:0] tick_cnt_r;
  logic [CW-1:0] tick_cnt_nxt;
  logic [1:0]    miss_r;
  logic [1:0]    miss_nxt;
  logic          sof_seen_r;
  logic          sof_seen_nxt;
  logic          susp_r;
  logic          susp_nxt;
  logic          tick;

  always_comb begin
    tick         = (tick_cnt_r == TICK_LAST);
    tick_cnt_nxt = tick ? CNT_ZERO : tick_cnt_r + CW'(1);
    sof_seen_nxt = sof_seen_r | evt.sof_ok;
    miss_nxt     = miss_r;
    susp_nxt     = susp_r;
    if (tick) begin
      sof_seen_nxt = evt.sof_ok;
      if (sof_seen_r || evt.sof_ok) begin
        miss_nxt = 2'h0;
      end else if (miss_r != udsr_pkg::MISS_LIMIT) begin
        miss_nxt = miss_r + 2'h1;
      end
    end
    if (miss_nxt == udsr_pkg::MISS_LIMIT) begin
      susp_nxt = 1'b1;
    end
    if (evt.resume || evt.bus_reset || evt.sof_ok) begin
      susp_nxt = 1'b0;
      miss_nxt = 2'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tick_cnt_r <= '0;
      miss_r     <= 2'h0;
      sof_seen_r <= 1'b0;
      susp_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      miss_r     <= miss_nxt;
      sof_seen_r <= sof_seen_nxt;
      susp_r     <= susp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Frame number and source flags
  // ----------------------------------------------------------------
  logic [udsr_pkg::FRAME_W-1:0] frame_r;
  logic [udsr_pkg::FRAME_W-1:0] frame_nxt;
  logic [31:0]                  flags_r;
  logic [31:0]                  flags_nxt;
  logic [31:0]                  set_vec;

  always_comb begin
    // Frame held across bus reset, content then undefined
    frame_nxt = evt.sof_ok ? evt.frame : frame_r;
    set_vec = 32'h0000_0000;
    set_vec[udsr_pkg::BIT_EP_LO +: udsr_pkg::EP_W] = evt.ep;
    set_vec[udsr_pkg::BIT_SHORT]  = evt.short_pkt;
    set_vec[udsr_pkg::BIT_PTICK]  = tick;
    set_vec[udsr_pkg::BIT_SOF]    = evt.sof_ok;
    set_vec[udsr_pkg::BIT_DONE]   = evt.dma_zero;
    set_vec[udsr_pkg::BIT_SUSP]   = susp_nxt & ~susp_r;
    set_vec[udsr_pkg::BIT_RESUME] = evt.resume;
    set_vec[udsr_pkg::BIT_BRESET] = evt.bus_reset;
    // Set wins over clear
    flags_nxt = (flags_r & ~irq_clear) | set_vec;
    flags_nxt[udsr_pkg::BIT_BUS] = susp_nxt;
    flags_nxt[31:24] = 8'h00;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      frame_r <= '0;
      flags_r <= udsr_pkg::FLAGS_RST;
    end else begin
      frame_r <= frame_nxt;
      flags_r <= flags_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Command/data port
  // ----------------------------------------------------------------
  udsr_pkg::udsr_acc_type acc_r;
  udsr_pkg::udsr_acc_type acc_nxt;
  logic [15:0] hi_r;
  logic [15:0] hi_nxt;
  logic        lock_r;
  logic        lock_nxt;
  logic [15:0] dout_r;
  logic [15:0] dout_nxt;
  logic        doe_r;
  logic        doe_nxt;
  logic        irq_r;
  logic        irq_nxt;
  logic        rd_ok;

  always_comb begin
    acc_nxt  = acc_r;
    hi_nxt   = hi_r;
    lock_nxt = lock_r | (susp_nxt & ~susp_r);
    dout_nxt = dout_r;
    doe_nxt  = 1'b0;
    irq_nxt  = |(flags_r & irq_enable_mask);
    rd_ok    = hreq.rd && !hreq.wr && !hreq.sel && !lock_r;
    if (hreq.wr && hreq.sel) begin
      case (hreq.data[7:0])
        udsr_pkg::CMD_FRAME:  acc_nxt = udsr_pkg::ACC_FRAME;
        udsr_pkg::CMD_IDENT:  acc_nxt = udsr_pkg::ACC_IDENT;
        udsr_pkg::CMD_IRQ:    acc_nxt = udsr_pkg::ACC_LOW;
        udsr_pkg::CMD_UNLOCK: acc_nxt = udsr_pkg::ACC_UNLOCK;
        default:              acc_nxt = udsr_pkg::ACC_IDLE;
      endcase
    end else if (hreq.wr && !hreq.sel) begin
      if (acc_r == udsr_pkg::ACC_UNLOCK && hreq.data == udsr_pkg::UNLOCK_CODE) begin
        lock_nxt = susp_nxt & ~susp_r;
      end
      acc_nxt = udsr_pkg::ACC_IDLE;
    end else if (rd_ok) begin
      case (acc_r)
        udsr_pkg::ACC_FRAME: begin
          dout_nxt = frame_word(frame_r);
          doe_nxt  = 1'b1;
          acc_nxt  = udsr_pkg::ACC_IDLE;
        end
        udsr_pkg::ACC_IDENT: begin
          dout_nxt = {udsr_pkg::IDENT_CODE_DEF, udsr_pkg::SI_VERSION_DEF};
          doe_nxt  = 1'b1;
          acc_nxt  = udsr_pkg::ACC_IDLE;
        end
        udsr_pkg::ACC_LOW: begin
          dout_nxt = flags_r[15:0];
          hi_nxt   = flags_r[31:16];
          doe_nxt  = 1'b1;
          acc_nxt  = udsr_pkg::ACC_HIGH;
        end
        udsr_pkg::ACC_HIGH: begin
          dout_nxt = hi_r;
          doe_nxt  = 1'b1;
          acc_nxt  = udsr_pkg::ACC_IDLE;
        end
        default: begin
          dout_nxt = udsr_pkg::WORD_RST;
          doe_nxt  = 1'b1;
          acc_nxt  = udsr_pkg::ACC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      acc_r  <= udsr_pkg::ACC_IDLE;
      hi_r   <= udsr_pkg::WORD_RST;
      lock_r <= 1'b0;
      dout_r <= udsr_pkg::WORD_RST;
      doe_r  <= 1'b0;
      irq_r  <= 1'b0;
    end else begin
      acc_r  <= acc_nxt;
      hi_r   <= hi_nxt;
      lock_r <= lock_nxt;
      dout_r <= dout_nxt;
      doe_r  <= doe_nxt;
      irq_r  <= irq_nxt;
    end
  end

  assign bus_dout    = dout_r;
  assign bus_doe     = doe_r;
  assign irq_out     = irq_r;
  assign suspend_out = susp_r;
  assign locked_out  = lock_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  frame_capture_a: assert property (evt.sof_ok |=> frame_r == $past(evt.frame))
    else $error("frame number not captured");
  frame_layout_a: assert property ((rd_ok && acc_r == udsr_pkg::ACC_FRAME)
      |=> bus_doe && bus_dout == {5'h00, $past(frame_r)})
    else $error("frame word layout wrong");
  ident_word_a: assert property ((rd_ok && acc_r == udsr_pkg::ACC_IDENT)
      |=> bus_doe && bus_dout == {udsr_pkg::IDENT_CODE_DEF, udsr_pkg::SI_VERSION_DEF})
    else $error("identity word wrong");
  two_words_a: assert property ((rd_ok && acc_r == udsr_pkg::ACC_LOW)
      |=> acc_r == udsr_pkg::ACC_HIGH && hi_r == $past(flags_r[31:16]))
    else $error("second word not prepared");
  ep_flag_a: assert property (evt.ep[0] |=> flags_r[udsr_pkg::BIT_EP_LO])
    else $error("endpoint flag not set");
  irq_gate_a: assert property (##1 irq_out == |($past(flags_r) & $past(irq_enable_mask)))
    else $error("interrupt gating wrong");
  bus_live_a: assert property (flags_r[udsr_pkg::BIT_BUS] == susp_r)
    else $error("bus state bit not live");
  event_bits_a: assert property (evt.dma_zero
      |=> flags_r[udsr_pkg::BIT_DONE])
    else $error("transfer done flag not set");
  ptick_a: assert property (tick |=> flags_r[udsr_pkg::BIT_PTICK] && tick_cnt_r == CNT_ZERO)
    else $error("pseudo tick flag missing");
  susp_edge_a: assert property ($rose(susp_r) |-> flags_r[udsr_pkg::BIT_SUSP] && lock_r)
    else $error("suspend change not flagged");
  lock_read_a: assert property ((lock_r && !hreq.wr) |=> !bus_doe)
    else $error("read answered while locked");
  reset_zero_a: assert property ($rose(rstn) |-> flags_r == udsr_pkg::FLAGS_RST && !bus_doe)
    else $error("status not zero after reset");

  // ----------------------------------------------------------------
  // Flag, suspend and port checks
  // ----------------------------------------------------------------
  short_flag_a: assert property (evt.short_pkt
      |=> flags_r[udsr_pkg::BIT_SHORT])
    else $error("short packet flag not set");
  sof_flag_a: assert property (evt.sof_ok
      |=> flags_r[udsr_pkg::BIT_SOF])
    else $error("frame start flag not set");
  resume_flag_a: assert property (evt.resume
      |=> flags_r[udsr_pkg::BIT_RESUME])
    else $error("resume flag not set");
  breset_flag_a: assert property (evt.bus_reset
      |=> flags_r[udsr_pkg::BIT_BRESET])
    else $error("bus reset flag not set");
  in_flag_a: assert property (evt.ep[1]
      |=> flags_r[udsr_pkg::BIT_EP_LO + 1])
    else $error("control IN flag not set");
  last_ep_flag_a: assert property (evt.ep[udsr_pkg::EP_W - 1]
      |=> flags_r[udsr_pkg::BIT_EP_LO + udsr_pkg::EP_W - 1])
    else $error("last endpoint flag not set");
  flag_clear_a: assert property ((irq_clear[udsr_pkg::BIT_DONE] && !evt.dma_zero)
      |=> !flags_r[udsr_pkg::BIT_DONE])
    else $error("flag not cleared");
  reserved_zero_a: assert property (flags_r[31:24] == 8'h00)
    else $error("reserved flag bits not zero");
  frame_hold_a: assert property (!evt.sof_ok
      |=> frame_r == $past(frame_r))
    else $error("frame number changed without frame start");
  tick_bound_a: assert property (tick_cnt_r <= TICK_LAST)
    else $error("tick counter out of range");
  susp_enter_a: assert property ((tick && !sof_seen_r && !evt.sof_ok && !evt.resume && !evt.bus_reset
      && miss_r == udsr_pkg::MISS_LIMIT - 2'h1) |=> susp_r)
    else $error("suspend not entered after missed frames");
  miss_clear_a: assert property ((tick && sof_seen_r)
      |=> miss_r == 2'h0)
    else $error("miss count not cleared by frame start");
  susp_leave_a: assert property ((evt.resume || evt.bus_reset || evt.sof_ok)
      |=> !susp_r)
    else $error("suspend not left on bus activity");
  lock_hold_a: assert property ((lock_r && !hreq.wr)
      |=> lock_r)
    else $error("lock dropped without a write");
  unlock_a: assert property ($fell(lock_r)
      |-> $past(hreq.wr) && !$past(hreq.sel) && $past(acc_r) == udsr_pkg::ACC_UNLOCK
          && $past(hreq.data) == udsr_pkg::UNLOCK_CODE)
    else $error("lock released without unlock code");
  low_word_a: assert property ((rd_ok && acc_r == udsr_pkg::ACC_LOW)
      |=> bus_doe && bus_dout == $past(flags_r[15:0]))
    else $error("low interrupt word wrong");
  high_word_a: assert property ((rd_ok && acc_r == udsr_pkg::ACC_HIGH)
      |=> bus_doe && bus_dout == $past(hi_r))
    else $error("high interrupt word wrong");
  idle_read_a: assert property ((rd_ok && acc_r == udsr_pkg::ACC_IDLE)
      |=> bus_doe && bus_dout == udsr_pkg::WORD_RST)
    else $error("read without command not zero");
  irq_cmd_a: assert property ((hreq.wr && hreq.sel && hreq.data[7:0] == udsr_pkg::CMD_IRQ)
      |=> acc_r == udsr_pkg::ACC_LOW)
    else $error("interrupt command not taken");
  ident_cmd_a: assert property ((hreq.wr && hreq.sel && hreq.data[7:0] == udsr_pkg::CMD_IDENT)
      |=> acc_r == udsr_pkg::ACC_IDENT)
    else $error("identity command not taken");
  wr_first_a: assert property (hreq.wr
      |=> !bus_doe)
    else $error("read answered during a write");
  answer_slot_a: assert property (bus_doe
      |-> $past(rd_ok))
    else $error("data driven without a read");

  irq_read_c:  cover property (acc_r == udsr_pkg::ACC_HIGH && rd_ok);
  refused_c:   cover property (lock_r && hreq.rd && !hreq.sel);
  suspend_c:   cover property ($rose(susp_r));
  unlock_c:    cover property ($fell(lock_r));
  frame_rd_c:  cover property (rd_ok && acc_r == udsr_pkg::ACC_FRAME);

endmodule : udsr_top

`default_nettype wire

// ==== logic/udsr_pkg.sv ====
// Constants and carrier types of the device status readout
package udsr_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_FRAME   = 8'hB4;
  localparam logic [7:0]  CMD_IDENT   = 8'hB5;
  localparam logic [7:0]  CMD_IRQ     = 8'hC0;
  localparam logic [7:0]  CMD_UNLOCK  = 8'hB0;
  localparam logic [15:0] UNLOCK_CODE = 16'hAA37;

  // ----------------------------------------------------------------
  // Identification word, values arbitrary
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDENT_CODE_DEF = 8'h5A;
  localparam logic [7:0]  SI_VERSION_DEF = 8'h10;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int FRAME_W      = 11;
  localparam int EP_W         = 16;
  localparam int BIT_EP_LO    = 8;
  localparam int BIT_BUS      = 7;
  localparam int BIT_SHORT    = 6;
  localparam int BIT_PTICK    = 5;
  localparam int BIT_SOF      = 4;
  localparam int BIT_DONE     = 3;
  localparam int BIT_SUSP     = 2;
  localparam int BIT_RESUME   = 1;
  localparam int BIT_BRESET   = 0;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  localparam logic [1:0]  MISS_LIMIT = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 100;
  localparam int PTICK_US     = 1000;
  localparam int PTICK_CYCLES = PTICK_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ACC_IDLE, ACC_FRAME, ACC_IDENT, ACC_LOW, ACC_HIGH, ACC_UNLOCK
  } udsr_acc_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        sel;
    logic [15:0] data;
  } udsr_hreq_type;

  typedef struct packed {
    logic [EP_W-1:0]    ep;
    logic               short_pkt;
    logic               dma_zero;
    logic               sof_ok;
    logic [FRAME_W-1:0] frame;
    logic               resume;
    logic               bus_reset;
  } udsr_evt_type;

endpackage : udsr_pkg

// ==== test/udsr_host_model.sv ====
// Host processor model on the command/data port
`timescale 1ns/1ns
`default_nettype none

module udsr_host_model (
  input  wire logic                    ref_clk,
  output var udsr_pkg::udsr_hreq_type  hreq,
  input  wire logic [15:0]             bus_dout,
  input  wire logic                    bus_doe
);
  initial hreq = '0;

  // ----------------------------------------------------------------
  // Phase tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic sel, input logic [15:0] d);
    @(posedge ref_clk);
    hreq <= '{wr: 1'b1, rd: 1'b0, sel: sel, data: d};
    @(posedge ref_clk);
    hreq.wr   <= 1'b0;
    hreq.data <= ~d;
  endtask : wr

  // Answer comes one cycle after the read edge
  task automatic rd(output logic [15:0] q, output logic ok);
    @(posedge ref_clk);
    hreq <= '{wr: 1'b0, rd: 1'b1, sel: 1'b0, data: 16'hFFFF};
    @(posedge ref_clk);
    hreq.rd <= 1'b0;
    #1;
    q  = bus_dout;
    ok = bus_doe;
  endtask : rd
endmodule : udsr_host_model

`default_nettype wire

// ==== test/udsr_top_tb.sv ====
// Self-checking bench of the status readout
`timescale 1ns/1ns
`default_nettype none

module udsr_top_tb;
  logic                    ref_clk = 1'b0;
  logic                    rstn = 1'b0;
  udsr_pkg::udsr_hreq_type hreq;
  udsr_pkg::udsr_evt_type  evt = '0;
  logic [31:0]             mask = '0;
  logic [31:0]             clr = '0;
  logic [15:0]             bus_dout;
  logic                    bus_doe;
  logic                    irq_out;
  logic                    suspend_out;
  logic                    locked_out;
  int                      miscompares = 0;
  int                      n_checks = 0;

  always #5 ref_clk = ~ref_clk;

  udsr_top #(.PTICK_CYCLES(400)) uut (
    .ref_clk(ref_clk), .rstn(rstn), .hreq(hreq), .evt(evt),
    .irq_enable_mask(mask), .irq_clear(clr), .bus_dout(bus_dout),
    .bus_doe(bus_doe), .irq_out(irq_out), .suspend_out(suspend_out),
    .locked_out(locked_out)
  );

  udsr_host_model host (
    .ref_clk(ref_clk), .hreq(hreq), .bus_dout(bus_dout), .bus_doe(bus_doe)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic pulse(input udsr_pkg::udsr_evt_type e);
    @(posedge ref_clk);
    evt <= e;
    @(posedge ref_clk);
    evt <= '0;
  endtask : pulse

  task automatic clear_all;
    @(posedge ref_clk);
    clr <= 32'hFFFF_FFFF;
    @(posedge ref_clk);
    clr <= 32'h0000_0000;
  endtask : clear_all

  // Command phase with junk upper byte, then n data reads
  task automatic read_reg(input logic [7:0] c, input int n, output logic [31:0] w, output logic ok);
    logic [15:0] q;
    logic        g;
    w  = '0;
    ok = 1'b1;
    host.wr(1'b1, {8'hFF, c});
    for (int i = 0; i < n; i++) begin
      host.rd(q, g);
      w[16*i+:16] = q;
      ok          = ok & g;
    end
  endtask : read_reg

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] w;
    logic        ok;
    read_reg(udsr_pkg::CMD_FRAME, 1, w, ok);
    chk(w, 32'h0000_0000);
    read_reg(udsr_pkg::CMD_IRQ, 2, w, ok);
    chk({31'h0, ok}, 32'h0000_0001);
    chk(w, 32'h0000_0000);
  endtask : t_reset

  task automatic t_frame_ident;
    udsr_pkg::udsr_evt_type e;
    logic [31:0]            w;
    logic                   ok;
    e       = '0;
    e.sof_ok = 1'b1;
    e.frame = 11'h5A3;
    pulse(e);
    read_reg(udsr_pkg::CMD_FRAME, 1, w, ok);
    chk(w, 32'h0000_05A3);
    read_reg(udsr_pkg::CMD_IDENT, 1, w, ok);
    chk(w, {16'h0000, udsr_pkg::IDENT_CODE_DEF, udsr_pkg::SI_VERSION_DEF});
    read_reg(8'h7E, 1, w, ok);
    chk(w, 32'h0000_0000);
    chk({31'h0, ok}, 32'h0000_0001);
  endtask : t_frame_ident

  task automatic t_flags;
    udsr_pkg::udsr_evt_type e;
    logic [31:0]            w;
    logic [31:0]            exp;
    logic                   ok;
    for (int i = 0; i < 8; i++) begin
      e = '0;
      case (i)
        0: begin e.ep = 16'h0001; exp = 32'h0000_0100; end
        1: begin e.ep = 16'h0002; exp = 32'h0000_0200; end
        2: begin e.ep = 16'h8000; exp = 32'h0080_0000; end
        3: begin e.short_pkt = 1'b1; exp = 32'h0000_0040; end
        4: begin e.dma_zero = 1'b1; exp = 32'h0000_0008; end
        5: begin e.sof_ok = 1'b1; exp = 32'h0000_0010; end
        6: begin e.resume = 1'b1; exp = 32'h0000_0002; end
        default: begin e.bus_reset = 1'b1; exp = 32'h0000_0001; end
      endcase
      clear_all();
      @(posedge ref_clk);
      mask <= (i % 2 == 0) ? exp : 32'h0000_0000;
      pulse(e);
      read_reg(udsr_pkg::CMD_IRQ, 2, w, ok);
      chk(w, exp);
      chk({31'h0, irq_out}, {31'h0, i % 2 == 0});
    end
    clear_all();
  endtask : t_flags

  task automatic t_suspend;
    logic [31:0] w;
    logic        ok;
    int          n;
    mask <= 32'h0000_0000;
    n = 0;
    while (suspend_out !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 3000) begin
        miscompares++;
        stop_test();
      end
    end
    chk({31'h0, locked_out}, 32'h0000_0001);
    read_reg(udsr_pkg::CMD_IRQ, 2, w, ok);
    chk({31'h0, ok}, 32'h0000_0000);
    pulse('{resume: 1'b1, default: '0});
    repeat (3) @(posedge ref_clk);
    #1;
    chk({31'h0, suspend_out}, 32'h0000_0000);
    read_reg(udsr_pkg::CMD_IRQ, 1, w, ok);
    chk({31'h0, ok}, 32'h0000_0000);
    host.wr(1'b1, {8'h00, udsr_pkg::CMD_UNLOCK});
    host.wr(1'b0, udsr_pkg::UNLOCK_CODE);
    read_reg(udsr_pkg::CMD_IRQ, 2, w, ok);
    chk({31'h0, ok}, 32'h0000_0001);
    chk(w & 32'hFF00_00A6, 32'h0000_0026);
  endtask : t_suspend

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_frame_ident();
    t_flags();
    t_suspend();
    stop_test();
  end
endmodule : udsr_top_tb

`default_nettype wire
